// >>> hw/plic_top.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - sixteen levels, level 15 highest priority, level 0 lowest
// - each level has its own register context, chosen by running level
// - external lines raise levels 10 to 13 and 15; identify gives 512 codes
// - level 14 is set only internally; external lines reach 10-13, 15
// - hardware raises 10-15; request register writes set requests for any level 0-15
// - accepted interrupt yields 5-bit vector joined to a fixed code
// - microcode request buffer raises requests on levels 10 to 15
// - request AND enable, priority encoder gives highest common bit
// - interrupt only when encoded level above current and system on
// - enable and request are 16 bits; hardware and software set requests
// - 4-bit current level register holds running level, picks context
// - pending above current with system on, or below it: skip fetch, run context change
// - block, save, copy level, load, fetch, in that order
// - whole level change takes 5.0 us
// - lower level resumes only when higher level gives up priority
// - system switched on or off by microprogram or on/off operations
// - identify searches level; first device returns 9-bit code
// - ten maskable internal condition sources drive level 14
// - an encoded internal condition also sets request bit 14
// - nothing is taken before the system is switched on
module plic_top
  import plic_pkg::*;
#(
  parameter int unsigned SWITCH_CYCLES = SWITCH_CYC,
  parameter int unsigned IDENT_TMO     = IDENT_TMO_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  ext_irq,
  input  wire logic [9:0]  int_cond,
  input  wire logic        mc_req_wr,
  input  wire logic [5:0]  mc_req_data,
  input  wire logic        mc_irq_on,
  input  wire logic        mc_irq_off,
  input  wire logic        instr_done,
  output logic             skip_fetch,
  output logic             ctx_save,
  output logic             ctx_load,
  output logic             ctx_fetch,
  output logic      [3:0]  ctx_level,
  output logic      [4:0]  irq_vector,
  output logic      [11:0] ub_branch,
  output logic             irq_blocked,
  output logic             ident_req,
  output logic      [3:0]  ident_level,
  input  wire logic        ident_ack,
  input  wire logic [8:0]  ident_code
);

  // ----------------------------------------------------------------
  // sizing
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = $clog2(SWITCH_CYCLES);
  localparam logic [CNT_W-1:0] SAVE_LEN =
    CNT_W'((SWITCH_CYCLES - 3) / 2 - 1);
  localparam logic [CNT_W-1:0] LOAD_LEN =
    CNT_W'(SWITCH_CYCLES - 3 - (SWITCH_CYCLES - 3) / 2 - 1);
  localparam logic [7:0] ID_TMO = 8'(IDENT_TMO - 1);

  generate
    if (SWITCH_CYCLES < 9 || IDENT_TMO < 2 || IDENT_TMO > 255)
    begin : g_bad
      $error("plic_top: unsupported switch or ident timing");
    end
  endgenerate

  typedef struct packed {
    logic [15:0]      en;
    logic [15:0]      req;
    logic             on;
    logic [9:0]       ien;
    logic [9:0]       idet;
    logic             icv;
    logic [3:0]       icode;
    logic [3:0]       cur;
    plic_ctx_t        st;
    logic [CNT_W-1:0] cnt;
    logic [4:0]       vec;
    plic_id_t         ist;
    logic [3:0]       ilev;
    logic [8:0]       id_code;
    logic             id_done;
    logic             id_none;
    logic [7:0]       icnt;
    logic             rdy;
    logic             err;
    logic [31:0]      rdata;
    logic [4:0]       s1;
    logic [4:0]       s2;
  } plic_st_t;

  localparam plic_st_t ST_RST = '{
    en: EN_RST, req: REQ_RST, on: 1'b0, ien: IEN_RST,
    idet: 10'h000, icv: 1'b0, icode: 4'h0, cur: LVL_RST,
    st: CTX_IDLE, cnt: '0, vec: 5'h00, ist: ID_IDLE,
    ilev: 4'h0, id_code: 9'h000, id_done: 1'b0,
    id_none: 1'b0, icnt: 8'h00, rdy: 1'b0, err: 1'b0,
    rdata: 32'h0, s1: 5'h00, s2: 5'h00};

  plic_st_t    r;
  plic_st_t    n;
  logic [15:0] ext_live;
  logic [15:0] pend;
  logic [15:0] en_pend;
  logic [3:0]  hp;
  logic [9:0]  int_act;
  logic [3:0]  int_code;
  logic        icode_rd;
  logic        fire;
  logic        wr;
  logic        trigger;
  logic [15:0] req_set;
  logic [31:0] rd_val;
  logic        rd_err;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // higher bit number wins
  function automatic logic [3:0] plic_enc(input logic [15:0] v);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 0; i < 16; i++)
      if (v[i])
        k = 4'(i);
    return k;
  endfunction

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // no external line reaches bit 14
  assign ext_live = {r.s2[4], 1'b0, r.s2[3:0], 10'h000};
  // lines stay live so a device drops its level when identified
  assign pend     = r.req | ext_live;
  assign en_pend  = r.en & pend;
  assign hp       = plic_enc(en_pend);
  assign int_act  = r.idet & r.ien;
  // power fail sits in the top bit, so it wins when two coincide
  assign int_code = plic_enc({6'h00, int_act});
  assign wr       = psel && penable && pwrite && r.rdy;
  assign icode_rd = psel && penable && !pwrite && r.rdy &&
                    paddr == A_ICODE;
  // encoding allowed while the code is free or being read
  assign fire     = (int_act != 10'h000) && (!r.icv || icode_rd);
  // up needs system on, down on release
  assign trigger  = r.st == CTX_IDLE && instr_done &&
                    ((hp > r.cur && r.on) || hp < r.cur);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n       = r;
    rd_val  = 32'h0;
    rd_err  = 1'b0;
    req_set = 16'h0000;
    n.s1    = ext_irq;
    n.s2    = r.s1;

    case (paddr)
      A_EN:    rd_val = {16'h0000, r.en};
      A_REQ:   rd_val = {16'h0000, pend};
      A_MBUF:  rd_val = 32'h0;
      A_CTRL:  rd_val = {31'h0, r.on};
      A_STAT:  rd_val = {18'h0, r.vec, r.st != CTX_IDLE, hp, r.cur};
      A_IEN:   rd_val = {22'h0, r.ien};
      A_IDET:  rd_val = {22'h0, r.idet};
      A_ICODE: rd_val = {27'h0, r.icv, r.icode};
      A_IDENT: rd_val = {14'h0, r.id_none, r.id_done, 7'h00, r.id_code};
      A_DROP:  rd_val = 32'h0;
      default: rd_err = 1'b1;
    endcase

    // one wait state so read data comes from a flop
    n.rdy = psel && penable && !r.rdy;
    if (n.rdy)
    begin
      n.rdata = rd_val;
      n.err   = rd_err;
    end

    if (wr && paddr == A_EN)
      n.en = pwdata[15:0];
    if (wr && paddr == A_IEN)
      n.ien = pwdata[9:0];

    // internal detect: hardware set wins over software clear
    n.idet = r.idet | int_cond;
    if (wr && paddr == A_IDET)
      n.idet = (r.idet & ~pwdata[9:0]) | int_cond;
    if (icode_rd)
      n.icv = 1'b0;
    if (fire)
    begin
      n.icv             = 1'b1;
      n.icode           = int_code;
      n.idet[int_code]  = int_cond[int_code];
      req_set[LVL_INT]  = 1'b1;
    end

    if (mc_req_wr)
      req_set[15:10] = req_set[15:10] | mc_req_data;
    if (wr && paddr == A_MBUF)
      req_set[15:10] = req_set[15:10] | pwdata[15:10];

    // software writes any level, sets are kept
    if (wr && paddr == A_REQ)
      n.req = pwdata[15:0];
    // current level gives up its priority
    if (wr && paddr == A_DROP)
      n.req[r.cur] = 1'b0;
    n.req = n.req | req_set;

    // system on/off; off wins when both arrive
    if (mc_irq_on || (wr && paddr == A_CTRL && pwdata[CTRL_ON_B]))
      n.on = 1'b1;
    if (mc_irq_off || (wr && paddr == A_CTRL && pwdata[CTRL_OFF_B]))
      n.on = 1'b0;

    case (r.st)
      CTX_IDLE:
        if (trigger)
        begin
          n.st  = CTX_BLOCK;
          // vector: direction flag and target level
          n.vec = {hp > r.cur, hp};
        end
      CTX_BLOCK:
      begin
        n.st  = CTX_SAVE;
        n.cnt = SAVE_LEN;
      end
      CTX_SAVE:
        if (r.cnt == '0)
          n.st = CTX_COPY;
        else
          n.cnt = r.cnt - 1'b1;
      CTX_COPY:
      begin
        n.cur = hp;
        n.st  = CTX_LOAD;
        n.cnt = LOAD_LEN;
      end
      CTX_LOAD:
        if (r.cnt == '0)
          n.st = CTX_FETCH;
        else
          n.cnt = r.cnt - 1'b1;
      CTX_FETCH:
        n.st = CTX_IDLE;
      default:
        n.st = CTX_IDLE;
    endcase

    // identify search on one vectored level
    case (r.ist)
      ID_IDLE:
        if (wr && paddr == A_IDENT)
        begin
          n.id_done = 1'b0;
          n.id_none = 1'b0;
          n.ilev    = pwdata[3:0];
          n.icnt    = ID_TMO;
          // only levels 10 to 13 carry devices
          if (pwdata[3:0] >= LVL_ID_LO && pwdata[3:0] <= LVL_ID_HI)
            n.ist = ID_WAIT;
          else
          begin
            n.id_done = 1'b1;
            n.id_none = 1'b1;
          end
        end
      ID_WAIT:
        if (ident_ack)
        begin
          n.id_code = ident_code;
          n.id_done = 1'b1;
          n.ist     = ID_IDLE;
        end
        else if (r.icnt == 8'h00)
        begin
          n.id_done = 1'b1;
          n.id_none = 1'b1;
          n.ist     = ID_IDLE;
        end
        else
          n.icnt = r.icnt - 1'b1;
      default:
        n.ist = ID_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= ST_RST;
    else
      r <= n;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = r.rdata;
  assign pready      = r.rdy;
  assign pslverr     = r.rdy && r.err;
  // fetch is held off for the whole change
  assign skip_fetch  = trigger || r.st != CTX_IDLE;
  assign ctx_save    = r.st == CTX_SAVE;
  assign ctx_load    = r.st == CTX_LOAD;
  assign ctx_fetch   = r.st == CTX_FETCH;
  // running level selects the register context
  assign ctx_level   = r.cur;
  assign irq_vector  = r.vec;
  // branch address into the interrupt microroutine
  assign ub_branch   = {BR_FIXED, r.vec};
  assign irq_blocked = r.st != CTX_IDLE;
  assign ident_req   = r.ist == ID_WAIT;
  assign ident_level = r.ilev;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [CNT_W:0] sw_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_cnt <= '0;
    else if (r.st == CTX_IDLE)
      sw_cnt <= '0;
    else
      sw_cnt <= sw_cnt + 1'b1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hp_highest_a: assert property (en_pend != 16'h0000 |->
    (en_pend >> hp) == 16'h0001)
    else $error("pending level is not the highest enabled request");
  hp_zero_a: assert property (en_pend == 16'h0000 |-> hp == 4'h0)
    else $error("pending level not zero with nothing pending");
  up_needs_on_a: assert property (trigger && hp > r.cur |-> r.on)
    else $error("interrupt taken with system off");
  switch_time_a: assert property (ctx_fetch |->
    sw_cnt == (CNT_W+1)'(SWITCH_CYCLES - 1))
    else $error("level change length wrong");
  seq_order_a: assert property (r.st == CTX_SAVE |=>
    r.st == CTX_SAVE || r.st == CTX_COPY)
    else $error("save phase left out of order");
  copy_level_a: assert property (r.st == CTX_COPY |=>
    r.cur == $past(hp) && r.st == CTX_LOAD)
    else $error("current level not copied from pending level");
  int_level_a: assert property (fire |=> r.req[LVL_INT] && r.icv)
    else $error("internal condition did not raise level 14");
  ident_take_a: assert property (ident_req && ident_ack |=>
    r.id_done && !r.id_none && r.id_code == $past(ident_code))
    else $error("ident code not captured");
  ident_lvl_a: assert property (ident_req |->
    ident_level >= LVL_ID_LO && ident_level <= LVL_ID_HI)
    else $error("ident search on non-vectored level");
  down_release_a: assert property (trigger && hp < r.cur |->
    !en_pend[r.cur])
    else $error("moved down while current level still pending");
  vec_form_a: assert property (r.st == CTX_BLOCK |->
    ub_branch == {BR_FIXED, $past(hp > r.cur), $past(hp)})
    else $error("vector does not match accepted level");

  up_switch_c:   cover property (trigger && hp > r.cur ##1 r.st == CTX_BLOCK);
  down_switch_c: cover property (trigger && hp < r.cur);
  ident_ok_c:    cover property (ident_req && ident_ack);
  ident_tmo_c:   cover property (ident_req ##1 r.id_none);
  int_fire_c:    cover property (fire && r.on);

endmodule

// >>> hw/plic_pkg.sv
package plic_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 250;
  // whole level change, in nanoseconds (5.0 us)
  localparam int unsigned SWITCH_NS     = 5000;
  // a fixed duration: rounded down to whole cycles
  localparam int unsigned SWITCH_CYC    = SWITCH_NS * CLK_MHZ / 1000;
  localparam int unsigned IDENT_TMO_CYC = 64;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] A_EN    = 8'h00;
  localparam logic [7:0] A_REQ   = 8'h04;
  localparam logic [7:0] A_MBUF  = 8'h08;
  localparam logic [7:0] A_CTRL  = 8'h0c;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_IEN   = 8'h14;
  localparam logic [7:0] A_IDET  = 8'h18;
  localparam logic [7:0] A_ICODE = 8'h1c;
  localparam logic [7:0] A_IDENT = 8'h20;
  localparam logic [7:0] A_DROP  = 8'h24;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ON_B  = 1;
  localparam int unsigned CTRL_OFF_B = 2;
  localparam logic [15:0] EN_RST     = 16'h0000;
  localparam logic [15:0] REQ_RST    = 16'h0000;
  localparam logic [9:0]  IEN_RST    = 10'h000;
  localparam logic [3:0]  LVL_RST    = 4'h0;
  localparam logic [3:0]  LVL_ID_LO  = 4'ha;
  localparam logic [3:0]  LVL_ID_HI  = 4'hd;
  localparam int unsigned LVL_INT    = 14;
  // upper part of the microprogram branch address
  localparam logic [6:0]  BR_FIXED   = 7'h3c;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CTX_IDLE  = 3'b000,
    CTX_BLOCK = 3'b001,
    CTX_SAVE  = 3'b011,
    CTX_COPY  = 3'b010,
    CTX_LOAD  = 3'b110,
    CTX_FETCH = 3'b111
  } plic_ctx_t;

  typedef enum logic [0:0] {
    ID_IDLE = 1'b0,
    ID_WAIT = 1'b1
  } plic_id_t;

endpackage

// >>> tb/plic_dev_model.sv
`timescale 1ns/1ps
module plic_dev_model
  import plic_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ident_req,
  input  wire logic [3:0] ident_level,
  output logic            ident_ack,
  output logic      [8:0] ident_code,
  output logic      [4:0] ext_irq
);
  // slot 0 sits nearest the processor; group 4 is the level 15 line
  logic [3:0] pend_m [5] = '{default: 4'h0};
  logic [8:0] code_m [5][4];
  int         delay_m = 2;
  int         wait_n;
  int         g;
  int         s;

  task automatic post(input int gi, input int si, input logic [8:0] c);
    pend_m[gi][si] = 1'b1;
    code_m[gi][si] = c;
  endtask

  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ident_ack  <= 1'b0;
      ident_code <= 9'h000;
      ext_irq    <= 5'h00;
      wait_n     <= 0;
    end
    else
    begin
      for (g = 0; g < 5; g++)
        ext_irq[g] <= |pend_m[g];
      g = int'(ident_level) - 10;
      s = -1;
      if (g >= 0 && g < 4)
        for (int k = 3; k >= 0; k--)
          if (pend_m[g][k])
            s = k;
      if (ident_req && !ident_ack && s >= 0 && wait_n >= delay_m)
      begin
        ident_ack    <= 1'b1;
        ident_code   <= code_m[g][s];
        pend_m[g][s] <= 1'b0;
        wait_n       <= 0;
      end
      else
      begin
        ident_ack  <= 1'b0;
        // released bus: shows the inverse of its last value
        ident_code <= ~ident_code;
        if (ident_req && !ident_ack && s >= 0)
          wait_n <= wait_n + 1;
      end
    end
endmodule

// >>> tb/plic_bench.sv
`timescale 1ns/1ps
module plic_bench
  import plic_pkg::*;
;
  localparam int SW = 21;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0]  ext_irq, irq_vector;
  logic [9:0]  int_cond;
  logic        mc_req_wr, mc_irq_on, mc_irq_off, instr_done;
  logic [5:0]  mc_req_data;
  logic        skip_fetch, ctx_save, ctx_load, ctx_fetch, irq_blocked;
  logic [3:0]  ctx_level, ident_level, cur, nx;
  logic [11:0] ub_branch;
  logic        ident_req, ident_ack;
  logic [8:0]  ident_code;
  logic [15:0] req, en;
  logic [64:0] ap_q [$];
  logic [64:0] ent;
  logic [4:0]  chg_q [$];
  logic [4:0]  exp_c;
  logic [7:0]  rst_a [6] = '{A_EN, A_REQ, A_CTRL, A_STAT, A_IEN, A_ICODE};
  int          num_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n_sv = 0;
  int          n_ld = 0;

  plic_top #(.SWITCH_CYCLES(SW), .IDENT_TMO(8)) plic_top_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .ext_irq, .int_cond, .mc_req_wr, .mc_req_data,
    .mc_irq_on, .mc_irq_off, .instr_done, .skip_fetch, .ctx_save,
    .ctx_load, .ctx_fetch, .ctx_level, .irq_vector, .ub_branch,
    .irq_blocked, .ident_req, .ident_level, .ident_ack, .ident_code);
  plic_dev_model plic_dev_model_i (
    .pclk, .presetn, .ident_req, .ident_level, .ident_ack, .ident_code,
    .ext_irq);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, m, input logic [32:0] e);
    int n;
    n = 0;
    ap_q.push_back({e[32], m, e[31:0]});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      check("apb timeout", 32'h1, 32'h0);
      conclude;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    apb(a, 1'b0, 32'h0, m, {1'b0, e});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while ((chg_q.size() != 0 || irq_blocked === 1'b1) && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200)
    begin
      check("change timeout", 32'h1, 32'h0);
      conclude;
    end
  endtask

  task automatic ident(input logic [3:0] l, input logic [31:0] m, e);
    int n;
    n = 0;
    wr(A_IDENT, {28'h0, l});
    // the search flag shows one edge after the write commits
    @(posedge pclk);
    check("ident_req", 32'(ident_req), 32'(l > 4'h9 && l < 4'he));
    while (ident_req === 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40)
    begin
      check("ident timeout", 32'h1, 32'h0);
      conclude;
    end
    check("ident_level", 32'(ident_level), 32'(l));
    @(posedge pclk);
    rd(A_IDENT, m, e);
  endtask

  function automatic logic [3:0] top_bit(input logic [15:0] v);
    top_bit = 4'h0;
    for (int i = 0; i < 16; i++)
      if (v[i])
        top_bit = 4'(i);
  endfunction

  // ----------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      ent = ap_q.pop_front();
      check("prdata", prdata & ent[63:32], ent[31:0] & ent[63:32]);
      check("pslverr", 32'(pslverr), 32'(ent[64]));
    end

  always @(posedge pclk)
  begin
    cyc = (irq_blocked === 1'b1) ? cyc + 1 : 0;
    n_sv = (irq_blocked === 1'b1) ? n_sv + int'(ctx_save === 1'b1) : 0;
    n_ld = (irq_blocked === 1'b1) ? n_ld + int'(ctx_load === 1'b1) : 0;
    if (ctx_fetch === 1'b1)
    begin
      if (chg_q.size() == 0)
        check("unexpected change", 32'h1, 32'h0);
      else
      begin
        exp_c = chg_q.pop_front();
        check("ctx_level", 32'(ctx_level), 32'(exp_c[3:0]));
        check("irq_vector", 32'(irq_vector), 32'(exp_c));
        check("ub_branch", 32'(ub_branch), 32'({BR_FIXED, exp_c}));
        check("switch cycles", 32'(cyc), 32'(SW));
        check("save cycles", 32'(n_sv), 32'((SW - 3) / 2));
        check("load cycles", 32'(n_ld), 32'(SW - 3 - (SW - 3) / 2));
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, mc_req_wr, mc_irq_on, mc_irq_off} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_cond = 10'h000;
    mc_req_data = 6'h00;
    instr_done = 1'b1;
    presetn = 1'b0;
    void'($urandom(32'hd30c));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_a[i])
      rd(rst_a[i], 32'hffffffff, 32'h0);
    apb(8'h40, 1'b0, 32'h0, 32'hffffffff, {1'b1, 32'h0});
    apb(8'h40, 1'b1, 32'h5, 32'h0, {1'b1, 32'h0});
    req = 16'($urandom()) | 16'h8001;
    wr(A_REQ, {16'h0, req});
    rd(A_REQ, 32'hffff, {16'h0, req});
    // system still off: encoder moves, level does not
    for (int k = 0; k < 6; k++)
    begin
      en = (k == 0) ? 16'h0 : 16'($urandom());
      wr(A_EN, {16'h0, en});
      rd(A_EN, 32'hffff, {16'h0, en});
      rd(A_STAT, 32'hff, {24'h0, top_bit(en & req), 4'h0});
    end
    wr(A_EN, 32'hffff);
    // no change may start while the running instruction is unfinished
    instr_done <= 1'b0;
    wr(A_CTRL, 32'h2);
    repeat (4)
    begin
      @(posedge pclk);
      check("skip_fetch", 32'(skip_fetch), 32'h0);
      check("irq_blocked", 32'(irq_blocked), 32'h0);
    end
    chg_q.push_back(5'h1f);
    instr_done <= 1'b1;
    @(posedge pclk);
    check("skip_fetch", 32'(skip_fetch), 32'h1);
    wait_idle();
    rd(A_CTRL, 32'h1, 32'h1);
    cur = 4'hf;
    // walk down by giving up each level in turn
    while (cur != 4'h0)
    begin
      req[cur] = 1'b0;
      nx = top_bit(req);
      chg_q.push_back({1'b0, nx});
      wr(A_DROP, 32'h0);
      wait_idle();
      cur = nx;
    end
    wr(A_CTRL, 32'h4);
    rd(A_CTRL, 32'h1, 32'h0);
    plic_dev_model_i.post(2, 1, 9'h1a5);
    plic_dev_model_i.post(2, 0, 9'h0c3);
    repeat (6) @(posedge pclk);
    rd(A_STAT, 32'hff, 32'hc0);
    chg_q.push_back(5'h1c);
    @(posedge pclk);
    mc_irq_on <= 1'b1;
    @(posedge pclk);
    mc_irq_on <= 1'b0;
    wait_idle();
    ident(4'hc, 32'h301ff, 32'h100c3);
    chg_q.push_back(5'h00);
    ident(4'hc, 32'h301ff, 32'h101a5);
    wait_idle();
    ident(4'hb, 32'h30000, 32'h30000);
    ident(4'h9, 32'h30000, 32'h30000);
    wr(A_IEN, 32'h3ff);
    rd(A_IEN, 32'h3ff, 32'h3ff);
    chg_q.push_back(5'h1e);
    @(posedge pclk);
    int_cond <= 10'h208;
    @(posedge pclk);
    int_cond <= 10'h000;
    wait_idle();
    rd(A_ICODE, 32'h1f, 32'h19);
    rd(A_ICODE, 32'h1f, 32'h13);
    rd(A_ICODE, 32'h10, 32'h00);
    rd(A_IDET, 32'h3ff, 32'h0);
    chg_q.push_back(5'h1f);
    @(posedge pclk);
    mc_req_wr <= 1'b1;
    mc_req_data <= 6'h20;
    @(posedge pclk);
    mc_req_wr <= 1'b0;
    wait_idle();
    @(posedge pclk);
    mc_irq_off <= 1'b1;
    @(posedge pclk);
    mc_irq_off <= 1'b0;
    rd(A_CTRL, 32'h1, 32'h0);
    conclude();
  end
endmodule
